// ---- logic/apc_pkg.sv ----
// package for the audio path control register bank
package apc_pkg;

  // ---------------------------------------------------------------
  // register indices on the control port
  // ---------------------------------------------------------------
  localparam logic [7:0] APC_ADR_DIG = 8'h02;
  localparam logic [7:0] APC_ADR_VCFG = 8'h03;
  localparam logic [7:0] APC_ADR_VOLL = 8'h04;
  localparam logic [7:0] APC_ADR_VOLR = 8'h05;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] APC_RST_DIG = 8'h14;
  localparam logic [7:0] APC_RST_VCFG = 8'h80;
  localparam logic [7:0] APC_RST_VOL = 8'hcf;
  localparam logic [7:0] APC_MSK_DIG = 8'hbf;
  localparam logic [7:0] APC_MSK_VCFG = 8'h83;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int APC_B_SKIP = 7;
  localparam int APC_B_SPEED = 3;
  localparam int APC_B_FADE = 7;
  localparam int APC_B_MUTER = 1;
  localparam int APC_B_MUTEL = 0;
  localparam logic [2:0] APC_FMT_MAX = 3'h5;
  localparam logic [7:0] APC_VOL_FLOOR = 8'h07;
  localparam logic [7:0] APC_VOL_MUTE = 8'h00;

  // ---------------------------------------------------------------
  // fade step period
  // ---------------------------------------------------------------
  localparam int APC_CLK_MHZ = 200;
  localparam int APC_FADE_STEP_US = 10;
  localparam int APC_FADE_CYC = APC_FADE_STEP_US * APC_CLK_MHZ;

  typedef enum logic [1:0] {APC_BOOST_0DB, APC_BOOST_6DB, APC_BOOST_12DB,
    APC_BOOST_18DB} apc_boost_e;

  // decoded digital path controls
  typedef struct packed {
    logic highpass_skip;
    apc_boost_e boost;
    logic rate_speed_select;
    logic [2:0] format;
  } apc_dig_s;

endpackage : apc_pkg

// ---- logic/apc_fade_chan.sv ----
// one channel's applied gain ramp toward its target code
`timescale 1ns/1ps
module apc_fade_chan
  import apc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_step,
  input wire logic i_fade_en,
  input wire logic [7:0] i_target,
  // applied gain code
  output logic [7:0] o_gain
);

  logic [7:0] gain_ff;
  logic [7:0] nxt_gain;

  // step one code per tick while fading, else jump
  assign nxt_gain = !i_fade_en ? i_target :
    (!i_step || gain_ff == i_target) ? gain_ff :
    (gain_ff < i_target) ? gain_ff + 8'h01 : gain_ff - 8'h01;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      gain_ff <= APC_RST_VOL;
    else
      gain_ff <= nxt_gain;
  end

  assign o_gain = gain_ff;

endmodule : apc_fade_chan

// ---- logic/apc_regs.sv ----
// audio path control registers with applied volume ramps
`timescale 1ns/1ps
module apc_regs
  import apc_pkg::*;
#(
  parameter int FADE_CYC = APC_FADE_CYC
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control port register access
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // decoded controls to the audio path
  output apc_dig_s o_dig,
  output logic [7:0] o_gain_l,
  output logic [7:0] o_gain_r,
  output logic o_mute_l,
  output logic o_mute_r
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] dig_ff;
  logic [7:0] vcfg_ff;
  logic [7:0] voll_ff;
  logic [7:0] volr_ff;
  logic [7:0] rdata_ff;
  logic [31:0] div_ff;
  logic step_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] nxt_dig;
  logic [31:0] nxt_div;

  // address decode
  wire sel_dig = i_wr && i_addr == APC_ADR_DIG;
  wire sel_vcfg = i_wr && i_addr == APC_ADR_VCFG;
  wire sel_voll = i_wr && i_addr == APC_ADR_VOLL;
  wire sel_volr = i_wr && i_addr == APC_ADR_VOLR;

  // reserved bits never take a write; bad format codes are dropped
  wire fmt_ok = i_wdata[2:0] <= APC_FMT_MAX;
  assign nxt_dig = fmt_ok ? (i_wdata & APC_MSK_DIG) :
    {i_wdata[7:3] & APC_MSK_DIG[7:3], dig_ff[2:0]};

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dig_ff <= APC_RST_DIG;
      vcfg_ff <= APC_RST_VCFG;
      voll_ff <= APC_RST_VOL;
      volr_ff <= APC_RST_VOL;
    end
    else
    begin
      if (sel_dig)
        dig_ff <= nxt_dig;
      if (sel_vcfg)
        vcfg_ff <= i_wdata & APC_MSK_VCFG;
      if (sel_voll)
        voll_ff <= i_wdata;
      if (sel_volr)
        volr_ff <= i_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read mux, registered; unmapped addresses read zero
  // ---------------------------------------------------------------
  assign nxt_rdata = !i_rd ? rdata_ff :
    (i_addr == APC_ADR_DIG) ? dig_ff :
    (i_addr == APC_ADR_VCFG) ? vcfg_ff :
    (i_addr == APC_ADR_VOLL) ? voll_ff :
    (i_addr == APC_ADR_VOLR) ? volr_ff : 8'h00;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  // ---------------------------------------------------------------
  // fade tick divider: one-cycle enable per step period
  // ---------------------------------------------------------------
  wire div_end = div_ff == 32'(FADE_CYC - 1);
  assign nxt_div = div_end ? 32'h0 : div_ff + 32'h1;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      div_ff <= 32'h0;
      step_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      step_ff <= div_end;
    end
  end

  // ---------------------------------------------------------------
  // target codes: soft mute or sub-floor code ramps down to zero
  // ---------------------------------------------------------------
  wire fade_en = vcfg_ff[APC_B_FADE];
  wire mute_l = vcfg_ff[APC_B_MUTEL] || voll_ff < APC_VOL_FLOOR;
  wire mute_r = vcfg_ff[APC_B_MUTER] || volr_ff < APC_VOL_FLOOR;
  wire [7:0] tgt_l = mute_l ? APC_VOL_MUTE : voll_ff;
  wire [7:0] tgt_r = mute_r ? APC_VOL_MUTE : volr_ff;
  logic [7:0] gain_l;
  logic [7:0] gain_r;

  apc_fade_chan u_fade_l (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_step(step_ff),
    .i_fade_en(fade_en),
    .i_target(tgt_l),
    .o_gain(gain_l)
  );

  apc_fade_chan u_fade_r (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_step(step_ff),
    .i_fade_en(fade_en),
    .i_target(tgt_r),
    .o_gain(gain_r)
  );

  // ---------------------------------------------------------------
  // outputs; mute asserts once the ramp reaches zero
  // ---------------------------------------------------------------
  assign o_rdata = rdata_ff;
  // reserved bit 6 is not carried; the struct packs bits 7 and 5:0
  assign o_dig = {dig_ff[APC_B_SKIP], dig_ff[5:0]};
  assign o_gain_l = gain_l;
  assign o_gain_r = gain_r;
  assign o_mute_l = mute_l && gain_l == APC_VOL_MUTE;
  assign o_mute_r = mute_r && gain_r == APC_VOL_MUTE;

endmodule : apc_regs

// ---- tb/apc_regs_props.sv ----
// concurrent checks on the audio path control register ports
`timescale 1ns/1ps
module apc_regs_props
  import apc_pkg::*;
#(
  parameter int FADE_CYC = 4
)
(
  // clock, reset and access
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  // outputs
  input wire logic [7:0] o_rdata,
  input wire apc_dig_s o_dig,
  input wire logic [7:0] o_gain_l,
  input wire logic [7:0] o_gain_r,
  input wire logic o_mute_l,
  input wire logic o_mute_r
);
  // digital control write decode
  wire dig_wr = i_wr && i_addr == APC_ADR_DIG;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  skip_bit_a: assert property (
    dig_wr |=> o_dig.highpass_skip == $past(i_wdata[7]))
    else $error("skip bit not taken");
  boost_field_a: assert property (
    dig_wr |=> o_dig.boost == $past(i_wdata[5:4]))
    else $error("boost not taken");
  speed_bit_a: assert property (
    dig_wr |=> o_dig.rate_speed_select == $past(i_wdata[3]))
    else $error("speed not taken");
  format_field_a: assert property (
    dig_wr && i_wdata[2:0] <= APC_FMT_MAX
    |=> o_dig.format == $past(i_wdata[2:0]))
    else $error("format not taken");
  mute_left_a: assert property (o_mute_l |-> o_gain_l == APC_VOL_MUTE)
    else $error("left mute with gain");
  mute_right_a: assert property (o_mute_r |-> o_gain_r == APC_VOL_MUTE)
    else $error("right mute with gain");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (
    i_rd && i_addr > APC_ADR_VOLR |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : apc_regs_props
bind apc_regs apc_regs_props #(.FADE_CYC(FADE_CYC)) u_props (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_dig(o_dig), .o_gain_l(o_gain_l),
  .o_gain_r(o_gain_r), .o_mute_l(o_mute_l), .o_mute_r(o_mute_r));

// ---- tb/apc_host_model.sv ----
// host model issuing control port writes and reads
`timescale 1ns/1ps
module apc_host_model
  import apc_pkg::*;
(
  // clock and read data
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  // access strobes
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  // idle bus shows inverted values so stale data never looks valid
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = a == APC_ADR_DIG ? d & APC_MSK_DIG :
      a == APC_ADR_VCFG ? d & APC_MSK_VCFG : d;
    if (a == APC_ADR_DIG && o_wdata[2:0] > APC_FMT_MAX)
      o_wdata[2:0] = APC_FMT_MAX;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~o_wdata;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
    o_addr = ~a;
  endtask : rd
endmodule : apc_host_model

// ---- tb/tb_top.sv ----
// self-checking bench for the audio path control registers
`timescale 1ns/1ps
module tb_top
  import apc_pkg::*;
();
  logic i_clk = 0, i_rst_n = 0, o_mute_l, o_mute_r;
  wire i_wr, i_rd;
  wire [7:0] i_addr, i_wdata;
  logic [7:0] o_rdata, o_gain_l, o_gain_r, w;
  apc_dig_s o_dig;
  int err_total = 0, n_tests = 0;
  always #2.5 i_clk = ~i_clk;
  apc_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr),
    .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  apc_regs #(.FADE_CYC(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_dig(o_dig), .o_gain_l(o_gain_l),
    .o_gain_r(o_gain_r), .o_mute_l(o_mute_l), .o_mute_r(o_mute_r));
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, e);
  endtask : chk_rd
  task finish_test;
    $display("errors %0d tests %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // fade is slow, so the wait is bounded generously
  task wait_gain(input logic [7:0] e);
    int k;
    for (k = 0; k < 2000 && o_gain_l !== e; k++) @(negedge i_clk);
    chk(o_gain_l, e);
    if (k == 2000) finish_test();
  endtask : wait_gain
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk(o_gain_r, APC_RST_VOL);
    chk_rd(APC_ADR_DIG, APC_RST_DIG);
    chk_rd(APC_ADR_VCFG, APC_RST_VCFG);
    chk_rd(APC_ADR_VOLL, APC_RST_VOL);
    chk_rd(APC_ADR_VOLR, APC_RST_VOL);
    chk_rd(8'h09, 8'h00);
    // every boost code and the valid format codes 0 to 5, both skip and speed values
    for (int i = 0; i < 6; i++)
    begin
      w = {i[0], 1'b0, i[1:0], i[1], i[2:0]};
      host.wr(APC_ADR_DIG, w);
      chk({1'b0, o_dig}, {1'b0, w[7], w[5:0]});
      chk_rd(APC_ADR_DIG, w);
    end
    host.wr(APC_ADR_VOLL, 8'h10);
    chk({7'h0, o_gain_l > 8'hc0}, 8'h01);
    wait_gain(8'h10);
    host.wr(APC_ADR_VCFG, 8'h00);
    host.wr(APC_ADR_VOLL, 8'h06);
    repeat (2) @(negedge i_clk);
    chk({o_gain_l, 7'h0, o_mute_l}, {8'h00, 8'h01});
    host.wr(APC_ADR_VOLL, 8'h07);
    repeat (2) @(negedge i_clk);
    chk({o_gain_l, 7'h0, o_mute_l}, {8'h07, 8'h00});
    host.wr(APC_ADR_VCFG, 8'h02);
    repeat (2) @(negedge i_clk);
    chk({o_gain_r, 6'h0, o_mute_r, o_mute_l}, {8'h00, 8'h02});
    host.wr(APC_ADR_VCFG, 8'h01);
    repeat (2) @(negedge i_clk);
    chk({o_gain_r, 6'h0, o_mute_r, o_mute_l}, {8'hcf, 8'h01});
    chk_rd(APC_ADR_VCFG, 8'h01);
    finish_test();
  end
endmodule : tb_top
